// *** src/err_status_pkg.sv ***
package err_status_pkg;

    // apb map, byte addresses
    localparam logic [7:0] ADDR_STATUS_LO = 8'h00;
    localparam logic [7:0] ADDR_STATUS_HI = 8'h04;
    localparam logic [7:0] ADDR_ENABLE_LO = 8'h08;
    localparam logic [7:0] ADDR_ENABLE_HI = 8'h0c;
    localparam logic [7:0] ADDR_CLEAR_LO = 8'h10;
    localparam logic [7:0] ADDR_CLEAR_HI = 8'h14;
    localparam logic [7:0] ADDR_ROUTER_HI = 8'h18;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int WORD_W = 64;

    // reset values
    localparam logic [63:0] STATUS_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] ENABLE_RESET = 64'h0000_0000_0000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // error word layout
    localparam int SYS_REQ_PAR_BIT = 0;
    localparam int SYS_OMUX_SRAM_BIT = 1;
    localparam int SYS_RING_OUT_SRAM_BIT = 2;
    localparam int SYS_SCAN_SRAM_BIT = 3;
    localparam int SYS_RING_IN_PAR_BIT = 4;
    localparam int SYS_IMUX_DATA_BIT = 5;
    localparam int SYS_UNUSED_BIT = 6;
    localparam int OMUX_BASE = 7;
    localparam int OMUX_STRIDE = 2;
    localparam int IMUX_BASE = 15;
    localparam int IMUX_STRIDE = 3;
    localparam int OMUX_FLOW_OFF = 0;
    localparam int OMUX_PAR_OFF = 1;
    localparam int IMUX_ECC_OFF = 0;
    localparam int IMUX_PAR_OFF = 1;
    localparam int IMUX_SRAM_OFF = 2;
    localparam int ACK_A_BASE = 27;
    localparam int ACK_B_BASE = 31;
    localparam int FIFO_OVF_BASE = 35;
    localparam int FIFO_UNF_BASE = 39;
    localparam int FIFO_PAR_BASE = 43;
    localparam int RIN_SRAM_BIT = 47;
    localparam int RIN_CHAN_BIT = 48;
    localparam int MSG_IN_PAR_BIT = 49;
    localparam int MSG_SEND_REJ_BIT = 50;
    localparam int MSG_RESP_PAR_BIT = 51;
    localparam int MSG_RESP_FMT_BIT = 52;
    localparam int MSG_REQ_PAR_BIT = 53;
    localparam int ERR_USED = 54;
    localparam int PORTS = 4;
    localparam int LAST_PORT = 3;

    // summary flag in the router status word and its place in the high word
    localparam int SUMMARY_BIT = 42;
    localparam int SUMMARY_HI_BIT = SUMMARY_BIT - DATA_W;
    localparam int IDLE_ERR_HI_BIT = 0;

    // buffer read sources checked for odd parity
    localparam int PS_OMUX_SRAM = 0;
    localparam int PS_RING_OUT_SRAM = 1;
    localparam int PS_SCAN_SRAM = 2;
    localparam int PS_OPORT_SRAM = 3;
    localparam int PS_IPORT_SRAM = 7;
    localparam int PS_FIFO = 11;
    localparam int PS_RIN_SRAM = 15;
    localparam int PAR_SRC_N = 16;
    localparam int BUF_W = 32;

    typedef struct packed {
        logic valid;
        logic [BUF_W-1:0] data;
        logic par;
    } buf_read_t;

    typedef struct packed {
        logic req_payload_par;
        logic ring_in_par;
        logic imux_data_par;
        logic [PORTS-1:0] omux_ovf_unf;
        logic [PORTS-1:0] imux_flit_ecc;
        logic [PORTS-1:0] imux_flit_par;
        logic [PORTS-1:0] ack_ovf_a;
        logic [PORTS-1:0] ack_ovf_b;
        logic [PORTS-1:0] fifo_ovf;
        logic [PORTS-1:0] fifo_unf;
        logic ring_chan_par;
        logic msg_in_par;
        logic msg_send_rej;
        logic msg_resp_par;
        logic msg_resp_fmt;
        logic msg_req_par;
    } err_event_t;

endpackage

// *** src/odd_parity_check.sv ***
`timescale 1ns/10ps
module odd_parity_check
    import err_status_pkg::*;
(
    input wire buf_read_t rd [PAR_SRC_N],
    output logic [PAR_SRC_N-1:0] par_err
);

    always_comb
    begin
        for (int i = 0; i < PAR_SRC_N; i++)
        begin
            par_err[i] = rd[i].valid & ~(^{rd[i].data, rd[i].par});
        end
    end

endmodule // odd_parity_check

// *** src/apb_reg_port.sv ***
`timescale 1ns/10ps
module apb_reg_port
    import err_status_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic addr_ok,
    input wire logic [DATA_W-1:0] rdata,
    output logic pready,
    output logic pslverr,
    output logic [DATA_W-1:0] prdata,
    output logic wr_en
);

    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;

    // read data captured in setup so the access phase shows a flop
    always_comb
    begin
        prdata_next = prdata_reg;
        if (psel && !penable)
        begin
            prdata_next = (!pwrite && addr_ok) ? rdata : READ_ZERO;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= READ_ZERO;
        end
        else
        begin
            prdata_reg <= prdata_next;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata = prdata_reg;
    assign wr_en = psel & penable & pwrite & addr_ok;

endmodule // apb_reg_port

// *** src/io_controller_error_status.sv ***
`timescale 1ns/10ps
//
// Contract
// - detected error sets its status bit
// - bits 0-5 system and scan errors, bit 6 unused
// - bits 7-14 output mux port pairs
// - bits 15-26 input mux three per port
// - bits 27-34 acknowledge queue overflows
// - bits 35-46 ring output fifo errors
// - bits 47-48 ring input channel errors
// - bits 49-53 message control errors
// - enable gates interrupt, flag still records
// - summary bit 42 on enabled new error
// - logged error raises idle packet error bit
// - buffer parity is odd, even flags
module io_controller_error_status
    import err_status_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire err_event_t err_event,
    input wire buf_read_t buf_read [PAR_SRC_N],
    input wire logic idle_sent,
    output logic idle_err_bit,
    output logic error_summary,
    output logic [WORD_W-1:0] error_status_word
);

    logic [WORD_W-1:0] status_reg;
    logic [WORD_W-1:0] status_next;
    logic [WORD_W-1:0] enable_reg;
    logic [WORD_W-1:0] enable_next;
    logic summary_reg;
    logic summary_next;
    logic idle_err_reg;
    logic idle_err_next;
    logic [PAR_SRC_N-1:0] par_err;
    logic [WORD_W-1:0] set_vec;
    logic [WORD_W-1:0] clr_vec;
    logic [WORD_W-1:0] new_err;
    logic [DATA_W-1:0] rdata;
    logic addr_ok;
    logic wr_en;
    logic wr_enable_lo;
    logic wr_enable_hi;
    logic wr_clear_lo;
    logic wr_clear_hi;
    logic wr_router_hi;

    function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        is_addr = (a == b);
    endfunction

    function automatic int omux_bit(input int p, input int off);
        omux_bit = OMUX_BASE + OMUX_STRIDE*(LAST_PORT-p) + off;
    endfunction

    function automatic int imux_bit(input int p, input int off);
        imux_bit = IMUX_BASE + IMUX_STRIDE*p + off;
    endfunction

    function automatic int fifo_bit(input int base, input int p);
        fifo_bit = base + LAST_PORT - p;
    endfunction

    odd_parity_check u_parity (
        .rd(buf_read),
        .par_err(par_err)
    );

    apb_reg_port u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .addr_ok(addr_ok),
        .rdata(rdata),
        .pready(pready),
        .pslverr(pslverr),
        .prdata(prdata),
        .wr_en(wr_en)
    );

    // address decode
    always_comb
    begin
        addr_ok = is_addr(paddr, ADDR_STATUS_LO) || is_addr(paddr, ADDR_STATUS_HI)
            || is_addr(paddr, ADDR_ENABLE_LO) || is_addr(paddr, ADDR_ENABLE_HI)
            || is_addr(paddr, ADDR_CLEAR_LO) || is_addr(paddr, ADDR_CLEAR_HI)
            || is_addr(paddr, ADDR_ROUTER_HI);
    end

    // write strobes per register
    always_comb
    begin
        wr_enable_lo = wr_en && is_addr(paddr, ADDR_ENABLE_LO);
        wr_enable_hi = wr_en && is_addr(paddr, ADDR_ENABLE_HI);
        wr_clear_lo = wr_en && is_addr(paddr, ADDR_CLEAR_LO);
        wr_clear_hi = wr_en && is_addr(paddr, ADDR_CLEAR_HI);
        wr_router_hi = wr_en && is_addr(paddr, ADDR_ROUTER_HI);
    end

    // error event map
    always_comb
    begin
        set_vec = STATUS_RESET;
        // system and scan control
        set_vec[SYS_REQ_PAR_BIT] = err_event.req_payload_par;
        set_vec[SYS_OMUX_SRAM_BIT] = par_err[PS_OMUX_SRAM];
        set_vec[SYS_RING_OUT_SRAM_BIT] = par_err[PS_RING_OUT_SRAM];
        set_vec[SYS_SCAN_SRAM_BIT] = par_err[PS_SCAN_SRAM];
        set_vec[SYS_RING_IN_PAR_BIT] = err_event.ring_in_par;
        set_vec[SYS_IMUX_DATA_BIT] = err_event.imux_data_par;
        set_vec[SYS_UNUSED_BIT] = 1'b0;
        // port 3 sits lowest
        for (int p = 0; p < PORTS; p++)
        begin
            set_vec[omux_bit(p, OMUX_FLOW_OFF)] = err_event.omux_ovf_unf[p];
            set_vec[omux_bit(p, OMUX_PAR_OFF)] = par_err[PS_OPORT_SRAM + p];
        end
        // port 0 sits lowest
        for (int p = 0; p < PORTS; p++)
        begin
            set_vec[imux_bit(p, IMUX_ECC_OFF)] = err_event.imux_flit_ecc[p];
            set_vec[imux_bit(p, IMUX_PAR_OFF)] = err_event.imux_flit_par[p];
            set_vec[imux_bit(p, IMUX_SRAM_OFF)] = par_err[PS_IPORT_SRAM + p];
        end
        // queues 0 to 3 in each group
        for (int p = 0; p < PORTS; p++)
        begin
            set_vec[ACK_A_BASE + p] = err_event.ack_ovf_a[p];
            set_vec[ACK_B_BASE + p] = err_event.ack_ovf_b[p];
        end
        // fifo 3 sits lowest in each group
        for (int p = 0; p < PORTS; p++)
        begin
            set_vec[fifo_bit(FIFO_OVF_BASE, p)] = err_event.fifo_ovf[p];
            set_vec[fifo_bit(FIFO_UNF_BASE, p)] = err_event.fifo_unf[p];
            set_vec[fifo_bit(FIFO_PAR_BASE, p)] = par_err[PS_FIFO + p];
        end
        // ring input and message control
        set_vec[RIN_SRAM_BIT] = par_err[PS_RIN_SRAM];
        set_vec[RIN_CHAN_BIT] = err_event.ring_chan_par;
        set_vec[MSG_IN_PAR_BIT] = err_event.msg_in_par;
        set_vec[MSG_SEND_REJ_BIT] = err_event.msg_send_rej;
        set_vec[MSG_RESP_PAR_BIT] = err_event.msg_resp_par;
        set_vec[MSG_RESP_FMT_BIT] = err_event.msg_resp_fmt;
        set_vec[MSG_REQ_PAR_BIT] = err_event.msg_req_par;
    end

    // write one to clear
    always_comb
    begin
        clr_vec = STATUS_RESET;
        if (wr_clear_lo)
        begin
            clr_vec[DATA_W-1:0] = pwdata;
        end
        if (wr_clear_hi)
        begin
            clr_vec[WORD_W-1:DATA_W] = pwdata;
        end
    end

    // sticky flags, set beats clear
    always_comb
    begin
        new_err = set_vec & ~status_reg;
        status_next = (status_reg & ~clr_vec) | set_vec;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_reg <= STATUS_RESET;
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    // interrupt enables, read-write
    always_comb
    begin
        enable_next = enable_reg;
        if (wr_enable_lo)
        begin
            enable_next[DATA_W-1:0] = pwdata;
        end
        if (wr_enable_hi)
        begin
            enable_next[WORD_W-1:DATA_W] = pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_reg <= ENABLE_RESET;
        end
        else
        begin
            enable_reg <= enable_next;
        end
    end

    // summary flag, new enabled error beats clear
    always_comb
    begin
        summary_next = summary_reg;
        if (wr_router_hi && pwdata[SUMMARY_HI_BIT])
        begin
            summary_next = 1'b0;
        end
        if (|(new_err & enable_reg))
        begin
            summary_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            summary_reg <= 1'b0;
        end
        else
        begin
            summary_reg <= summary_next;
        end
    end

    // idle packet error bit, event beats send
    always_comb
    begin
        idle_err_next = idle_err_reg;
        if (idle_sent)
        begin
            idle_err_next = 1'b0;
        end
        if (|set_vec)
        begin
            idle_err_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idle_err_reg <= 1'b0;
        end
        else
        begin
            idle_err_reg <= idle_err_next;
        end
    end

    // read mux
    always_comb
    begin
        rdata = READ_ZERO;
        if (is_addr(paddr, ADDR_STATUS_LO))
        begin
            rdata = status_reg[DATA_W-1:0];
        end
        else if (is_addr(paddr, ADDR_STATUS_HI))
        begin
            rdata = status_reg[WORD_W-1:DATA_W];
        end
        else if (is_addr(paddr, ADDR_ENABLE_LO))
        begin
            rdata = enable_reg[DATA_W-1:0];
        end
        else if (is_addr(paddr, ADDR_ENABLE_HI))
        begin
            rdata = enable_reg[WORD_W-1:DATA_W];
        end
        else if (is_addr(paddr, ADDR_ROUTER_HI))
        begin
            rdata[SUMMARY_HI_BIT] = summary_reg;
            rdata[IDLE_ERR_HI_BIT] = idle_err_reg;
        end
    end

    assign idle_err_bit = idle_err_reg;
    assign error_summary = summary_reg;
    assign error_status_word = status_reg;

endmodule // io_controller_error_status

// *** verification/io_controller_error_status_monitor.sv ***
`timescale 1ns/10ps
module io_controller_error_status_monitor
    import err_status_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire err_event_t err_event,
    input wire buf_read_t buf_read [PAR_SRC_N],
    input wire logic idle_err_bit,
    input wire logic error_summary,
    input wire logic [WORD_W-1:0] error_status_word
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sticky_flags_a: assert property (!(psel && penable && pwrite) |=>
        ($past(error_status_word) & ~error_status_word) == '0) else $error("flag dropped");
    req_par_a: assert property (err_event.msg_req_par |=> error_status_word[53]) else $error("bit 53");
    ack_b_a: assert property (err_event.ack_ovf_b[0] |=> error_status_word[31]) else $error("bit 31");
    fifo_ovf_a: assert property (err_event.fifo_ovf[0] |=> error_status_word[38]) else $error("bit 38");
    omux_port_a: assert property (err_event.omux_ovf_unf[3] |=> error_status_word[7]) else $error("bit 7");
    unused_zero_a: assert property (error_status_word[6] == 1'b0 && error_status_word[63:54] == '0)
        else $error("unused bit set");
    fifo_parity_a: assert property (buf_read[PS_FIFO].valid &&
        !(^{buf_read[PS_FIFO].data, buf_read[PS_FIFO].par}) |=> error_status_word[46]) else $error("bit 46");
    idle_flag_a: assert property (err_event != '0 |=> idle_err_bit) else $error("idle bit");
    summary_new_a: assert property ($rose(error_summary) |->
        (error_status_word & ~$past(error_status_word)) != '0) else $error("summary without new flag");
endmodule // io_controller_error_status_monitor
bind io_controller_error_status io_controller_error_status_monitor io_controller_error_status_monitor_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .err_event, .buf_read,
    .idle_err_bit, .error_summary, .error_status_word);

// *** verification/io_controller_error_status_tb_top.sv ***
`timescale 1ns/10ps
module io_controller_error_status_tb_top
    import err_status_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, idle_sent;
    logic pready, pslverr, idle_err_bit, error_summary, serr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [WORD_W-1:0] error_status_word;
    logic [$bits(err_event_t)-1:0] ev;
    err_event_t err_event;
    buf_read_t buf_read [PAR_SRC_N];
    int failures = 0;
    int n_compared = 0;
    io_controller_error_status io_controller_error_status_i (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .err_event, .buf_read, .idle_sent, .idle_err_bit,
        .error_summary, .error_status_word);
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic check(input logic [63:0] got, input logic [63:0] want);
        n_compared++;
        if (got !== want)
        begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input err_event_t e);
        @(posedge pclk);
        err_event <= e;
        @(posedge pclk);
        err_event <= '0;
        @(negedge pclk);
    endtask
    task automatic clr();
        apb(1'b1, ADDR_CLEAR_LO, 32'hffff_ffff);
        apb(1'b1, ADDR_CLEAR_HI, 32'hffff_ffff);
        @(negedge pclk);
        check(error_status_word, 64'h0);
    endtask
    function automatic int ev_bit(input int k);
        if (k < 6) return 53 - k;
        if (k < 14) return 48 - k;
        if (k < 18) return 17 + k;
        if (k < 22) return 9 + k;
        if (k < 26) return 3 * k - 50;
        if (k < 30) return 3 * k - 63;
        if (k < 34) return 73 - 2 * k;
        return k == 34 ? 5 : (k == 35 ? 4 : 0);
    endfunction
    function automatic int par_bit(input int s);
        if (s < 3) return s + 1;
        if (s < 7) return 20 - 2 * s;
        if (s < 11) return 3 * s - 4;
        if (s < 15) return 57 - s;
        return 47;
    endfunction
    task automatic final_report();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #1_000_000;
        failures++;
        final_report();
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        idle_sent = 1'b0;
        err_event = '0;
        foreach (buf_read[i]) buf_read[i] = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 7; a++)
        begin
            apb(1'b0, 8'(4 * a), 32'h0);
            check({32'h0, rd}, 64'h0);
        end
        apb(1'b0, 8'h1c, 32'h0);
        check({63'h0, serr}, 64'h1);
        $display("reset and map test done");
        for (int k = 0; k < $bits(err_event_t); k++)
        begin
            ev = '0;
            ev[k] = 1'b1;
            pulse(ev);
            check(error_status_word, 64'h1 << ev_bit(k));
            check({63'h0, idle_err_bit}, 64'h1);
            clr();
        end
        $display("event map test done");
        for (int s = 0; s < PAR_SRC_N; s++)
        begin
            @(posedge pclk);
            buf_read[s] <= '{1'b1, 32'h0000_0003, 1'b1};
            @(posedge pclk);
            buf_read[s] <= '{1'b1, 32'h0000_0003, 1'b0};
            @(negedge pclk);
            check(error_status_word, 64'h0);
            @(posedge pclk);
            buf_read[s] <= '0;
            @(negedge pclk);
            check(error_status_word, 64'h1 << par_bit(s));
            clr();
        end
        $display("parity test done");
        ev = '0;
        ev[0] = 1'b1;
        pulse(ev);
        check({62'h0, error_summary, error_status_word[53]}, 64'h1);
        clr();
        apb(1'b1, ADDR_ENABLE_HI, 32'h0020_0000);
        apb(1'b0, ADDR_ENABLE_HI, 32'h0);
        check({32'h0, rd}, 64'h0020_0000);
        pulse(ev);
        check({63'h0, error_summary}, 64'h1);
        apb(1'b0, ADDR_ROUTER_HI, 32'h0);
        check({32'h0, rd}, 64'h401);
        apb(1'b1, ADDR_ROUTER_HI, 32'h0000_0400);
        apb(1'b1, ADDR_STATUS_HI, 32'h0);
        pulse(ev);
        check({63'h0, error_summary}, 64'h0);
        check(error_status_word, 64'h0020_0000_0000_0000);
        @(posedge pclk);
        idle_sent <= 1'b1;
        @(posedge pclk);
        idle_sent <= 1'b0;
        @(negedge pclk);
        check({63'h0, idle_err_bit}, 64'h0);
        $display("enable and summary test done");
        pulse(ev);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check(error_status_word, 64'h0);
        check({63'h0, idle_err_bit}, 64'h0);
        $display("mid-run reset test done");
        final_report();
    end
endmodule // io_controller_error_status_tb_top
